// ### core/rcr_pkg.sv
// reset cause register: shared constants and types
// assumes a single 250 MHz system clock shared by all users
package rcr_pkg;
    localparam logic [7:0] RCR_ADDR       = 8'hEF;
    // bit positions inside reset_cause_control
    localparam int         RCR_BIT_FLASH  = 6;
    localparam int         RCR_BIT_COMP   = 5;
    localparam int         RCR_BIT_SOFT   = 4;
    localparam int         RCR_BIT_WDOG   = 3;
    localparam int         RCR_BIT_CLOCK  = 2;
    localparam int         RCR_BIT_POWER  = 1;
    localparam int         RCR_BIT_PIN    = 0;
    localparam int         RCR_NCAUSE     = 7;
    // flag value after power-on: only the power/supply flag reads 1
    localparam logic [6:0] RCR_FLAGS_RST  = 7'h02;
    localparam logic       RCR_EN_RST     = 1'h0;
    // synchroniser lanes and their idle levels (pin high, supply good)
    localparam int         RCR_SY_COMP    = 0;
    localparam int         RCR_SY_PIN     = 1;
    localparam int         RCR_SY_SUP     = 2;
    localparam int         RCR_SY_CLK     = 3;
    localparam int         RCR_SY_W       = 4;
    localparam logic [3:0] RCR_SY_RST     = 4'h7;
    // shortest system reset pulse
    localparam int         RCR_HOLD_NS    = 100;
    localparam int         RCR_CLK_MHZ    = 250;
    localparam int         RCR_HOLD_CYC   =
        (RCR_HOLD_NS * RCR_CLK_MHZ + 999) / 1000;

    typedef enum logic [0:0] {
        RCR_RUN  = 1'b0,
        RCR_HOLD = 1'b1
    } rcr_state_type;
endpackage : rcr_pkg

// ### core/rcr_sync.sv
// reset cause register: two-flop synchroniser per lane
// assumes raw levels are asynchronous to clk
`timescale 1ns/100ps
module rcr_sync
    import rcr_pkg::*;
#(
    parameter int              W       = RCR_SY_W,
    parameter logic [W-1:0]    RST_VAL = RCR_SY_RST
) (
    input  wire logic clk,         // system clock
    input  wire logic rst_n,       // synchronous reset, active low
    input  wire logic ce,          // clock enable
    rcr_sync_if.sink  sif          // raw in, synchronised out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] safe;
    } rcr_sync_state_type;

    rcr_sync_state_type q;
    rcr_sync_state_type d;

    // refuse a lane count the synchroniser cannot hold
    if (W < 1) begin : gen_w_check
        $error("rcr_sync: W must be at least 1");
    end

    always_comb begin
        d      = q;
        d.meta = sif.raw;
        d.safe = q.meta;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q.meta <= RST_VAL;
            q.safe <= RST_VAL;
        end else if (ce) begin
            q <= d;
        end
    end

    assign sif.sync = q.safe;
endmodule : rcr_sync

// ### core/rcr_sync_if.sv
// reset cause register: raw and synchronised source levels
// assumes the owner drives raw and the synchroniser drives sync
`timescale 1ns/100ps
interface rcr_sync_if #(parameter int W = 4);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport src  (output raw, input sync);
    modport sink (input raw, output sync);
endinterface : rcr_sync_if

// ### core/rcr_top.sv
// reset cause register: cause capture, source enables, soft reset
// assumes rst_n is the power-on reset of this block only; the system
// reset it requests leaves this block running so flags survive it
//
// Notes on behaviour
// - register answers at address 0xEF on every page, no page select.
// - bit 6 reads 1 after a flash access fault reset.
// - bit 5 written 1 enables comparator reset while its output is low.
// - writing 1 to bit 4 starts a system reset at once.
// - bit 4 reads 1 only after a software reset.
// - bit 3 reads 1 only after a watchdog overflow reset.
// - bit 2 written 1 enables the stalled clock detector reset.
// - bit 2 reads 1 only after a stalled clock reset.
// - bit 1 written 1 enables the supply monitor reset.
// - bit 1 reads 1 after power-on or supply monitor reset.
// - when bit 1 reads 1 the other flags carry no meaning.
// - bit 0 reads 1 only after an external pin reset.
// - writing 0 to bit 2 disables stalled clock resets.
// - bit 5 reads 1 only after a comparator reset.
`timescale 1ns/100ps
module rcr_top
    import rcr_pkg::*;
#(
    parameter int HOLD_CYC = RCR_HOLD_CYC
) (
    input  wire logic       clk,             // system clock, 250 MHz
    input  wire logic       rst_n,           // power-on reset, active low
    input  wire logic       ce,              // clock enable
    input  wire logic [7:0] sfr_addr,        // register address
    input  wire logic       sfr_wr,          // write strobe
    input  wire logic       sfr_rd,          // read strobe
    input  wire logic [7:0] sfr_wdata,       // write data
    output logic      [7:0] sfr_rdata,       // read data, one cycle later
    input  wire logic       flash_fault,     // flash access fault pulse
    input  wire logic       wdog_overflow,   // watchdog overflow pulse
    input  wire logic       comp_out,        // comparator output, async
    input  wire logic       clk_stall,       // clock detector timeout, async
    input  wire logic       supply_ok,       // supply above threshold, async
    input  wire logic       reset_pin_n,     // external reset pin, async
    output logic            sys_rst_req,     // system reset request
    output logic            comp_rst_en,     // comparator reset enabled
    output logic            clk_det_en,      // stalled clock detector on
    output logic            sup_rst_en       // supply monitor reset enabled
);
    localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYC - 1);

    typedef struct packed {
        rcr_state_type           state;
        logic [7:0]              cnt;
        logic [RCR_NCAUSE-1:0]   pending;
        logic [RCR_NCAUSE-1:0]   flags;
        logic                    en_comp;
        logic                    en_clk;
        logic                    en_sup;
        logic [7:0]              rdata;
    } rcr_top_state_type;

    rcr_top_state_type     q;
    rcr_top_state_type     d;
    logic [RCR_NCAUSE-1:0] cause;
    logic                  level_src;
    logic                  sel;

    rcr_sync_if #(.W(RCR_SY_W)) sif ();

    // the hold counter is eight bits wide
    if (HOLD_CYC < 1 || HOLD_CYC > 256) begin : gen_hold_check
        $error("rcr_top: HOLD_CYC must lie in 1..256");
    end

    assign sif.raw[RCR_SY_COMP] = comp_out;
    assign sif.raw[RCR_SY_PIN]  = reset_pin_n;
    assign sif.raw[RCR_SY_SUP]  = supply_ok;
    assign sif.raw[RCR_SY_CLK]  = clk_stall;

    rcr_sync #(
        .W       (RCR_SY_W),
        .RST_VAL (RCR_SY_RST)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .sif   (sif)
    );

    assign sel = (sfr_addr == RCR_ADDR);

    always_comb begin
        cause = '0;
        cause[RCR_BIT_FLASH] = flash_fault;
        cause[RCR_BIT_COMP]  = q.en_comp & ~sif.sync[RCR_SY_COMP];
        cause[RCR_BIT_SOFT]  = (q.state == RCR_RUN) & sfr_wr & sel
                               & sfr_wdata[RCR_BIT_SOFT];
        cause[RCR_BIT_WDOG]  = wdog_overflow;
        cause[RCR_BIT_CLOCK] = q.en_clk & sif.sync[RCR_SY_CLK];
        cause[RCR_BIT_POWER] = q.en_sup & ~sif.sync[RCR_SY_SUP];
        cause[RCR_BIT_PIN]   = ~sif.sync[RCR_SY_PIN];
        // level sources restart the hold count; in hold only the pin can, as the other enables are cleared
        level_src = cause[RCR_BIT_COMP] | cause[RCR_BIT_CLOCK]
                    | cause[RCR_BIT_POWER] | cause[RCR_BIT_PIN];
    end

    always_comb begin
        d       = q;
        d.rdata = 8'h00;
        // reads return flags, never the enable settings
        if (sfr_rd && sel) begin
            d.rdata = {1'b0, q.flags};
        end
        unique case (q.state)
            RCR_RUN: begin
                if (sfr_wr && sel) begin
                    d.en_comp = sfr_wdata[RCR_BIT_COMP];
                    d.en_clk  = sfr_wdata[RCR_BIT_CLOCK];
                    d.en_sup  = sfr_wdata[RCR_BIT_POWER];
                end
                // enables drop on entry so a lingering low comparator
                // or supply cannot keep the system in reset for ever
                if (|cause) begin
                    d.state   = RCR_HOLD;
                    d.cnt     = HOLD_LAST;
                    d.pending = cause;
                    d.en_comp = RCR_EN_RST;
                    d.en_clk  = RCR_EN_RST;
                    d.en_sup  = RCR_EN_RST;
                end
            end
            RCR_HOLD: begin
                // every cause seen during the reset is kept
                d.pending = q.pending | cause;
                if (level_src) begin
                    d.cnt = HOLD_LAST;
                end else if (q.cnt == 8'h00) begin
                    d.flags   = q.pending | cause;
                    d.pending = '0;
                    d.state   = RCR_RUN;
                end else begin
                    d.cnt = q.cnt - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q.state   <= RCR_RUN;
            q.cnt     <= 8'h00;
            q.pending <= '0;
            q.flags   <= RCR_FLAGS_RST;
            q.en_comp <= RCR_EN_RST;
            q.en_clk  <= RCR_EN_RST;
            q.en_sup  <= RCR_EN_RST;
            q.rdata   <= 8'h00;
        end else if (ce) begin
            q <= d;
        end
    end

    assign sfr_rdata   = q.rdata;
    assign sys_rst_req = (q.state == RCR_HOLD);
    assign comp_rst_en = q.en_comp;
    assign clk_det_en  = q.en_clk;
    assign sup_rst_en  = q.en_sup;
endmodule : rcr_top

// ### tb/rcr_asserts.sv
// checker for rcr_top: bus answers and reset request timing
// assumes ce low only stretches reset, which is counted in clk cycles
`timescale 1ns/100ps
module rcr_asserts
    import rcr_pkg::*;
#(
    parameter int HOLD_CYC = RCR_HOLD_CYC
) (
    input wire logic       clk,           // clock
    input wire logic       rst_n,         // reset
    input wire logic       ce,            // enable
    input wire logic [7:0] sfr_addr,      // address
    input wire logic       sfr_wr,        // write
    input wire logic       sfr_rd,        // read
    input wire logic [7:0] sfr_wdata,     // wdata
    input wire logic [7:0] sfr_rdata,     // rdata
    input wire logic       flash_fault,   // flash
    input wire logic       wdog_overflow, // watchdog
    input wire logic       reset_pin_n,   // pin
    input wire logic       sys_rst_req,   // request
    input wire logic       comp_rst_en,   // comp en
    input wire logic       clk_det_en,    // clock en
    input wire logic       sup_rst_en     // supply en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [8:0] hold_cnt_q;
    logic       wr_sel;
    assign wr_sel = ce && sfr_wr && sfr_addr == RCR_ADDR && !sys_rst_req;
    always_ff @(posedge clk) begin
        hold_cnt_q <= (!rst_n || !sys_rst_req) ? 9'h000 : hold_cnt_q + 9'h001;
    end
    chk_other_addr_zero: assert property (
        ce && sfr_rd && sfr_addr != RCR_ADDR |=> sfr_rdata == 8'h00)
        else $error("foreign read not zero");
    chk_read_top_zero: assert property (
        ce && sfr_rd && sfr_addr == RCR_ADDR |=> !sfr_rdata[7])
        else $error("unused bit not zero");
    chk_soft_reset_start: assert property (
        wr_sel && sfr_wdata[4] |=> sys_rst_req)
        else $error("soft reset missing");
    chk_reset_hold_len: assert property (
        $fell(sys_rst_req) |-> hold_cnt_q >= HOLD_CYC)
        else $error("reset too short");
    chk_enables_off_held: assert property (
        sys_rst_req |-> !comp_rst_en && !clk_det_en && !sup_rst_en)
        else $error("enable set during reset");
    chk_flash_reset_start: assert property (
        ce && flash_fault && !sys_rst_req |=> sys_rst_req)
        else $error("flash reset missing");
    chk_wdog_reset_start: assert property (
        ce && wdog_overflow && !sys_rst_req |=> sys_rst_req)
        else $error("watchdog reset missing");
    chk_pin_reset_held: assert property (
        !reset_pin_n [*4] |-> sys_rst_req)
        else $error("pin reset missing");
    chk_comp_en_write: assert property (
        wr_sel |=> sys_rst_req || comp_rst_en == $past(sfr_wdata[5]))
        else $error("comp enable not taken");
    chk_clock_en_write: assert property (
        wr_sel |=> sys_rst_req || clk_det_en == $past(sfr_wdata[2]))
        else $error("clock enable not taken");
    chk_supply_en_write: assert property (
        wr_sel |=> sys_rst_req || sup_rst_en == $past(sfr_wdata[1]))
        else $error("supply enable not taken");
endmodule : rcr_asserts

bind rcr_top rcr_asserts #(.HOLD_CYC(HOLD_CYC)) chk_u (.clk, .rst_n, .ce,
    .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .flash_fault,
    .wdog_overflow, .reset_pin_n, .sys_rst_req, .comp_rst_en, .clk_det_en,
    .sup_rst_en);

// ### tb/reset_cause_register_test.sv
// bench for rcr_top: each reset cause in turn, then flag readback
// assumes a short hold count; ce high except for one frozen write
`timescale 1ns/100ps
module reset_cause_register_test;
    import rcr_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       ce = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [5:0] src = 6'h00;
    logic [7:0] sfr_rdata;
    logic       sys_rst_req, comp_rst_en, clk_det_en, sup_rst_en, seen;
    int         err_total = 0;
    int         checks_done = 0;
    logic [7:0] en_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h04, 8'h02,
        8'h10};
    logic [7:0] exp_tab [7] = '{8'h08, 8'h40, 8'h01, 8'h20, 8'h04, 8'h02,
        8'h10};
    // source lanes: 0 wdog, 1 flash, 2 pin, 3 comp, 4 stall, 5 supply
    rcr_top #(.HOLD_CYC(3)) dut_u (.clk, .rst_n, .ce, .sfr_addr,
        .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .flash_fault(src[1]),
        .wdog_overflow(src[0]), .comp_out(!src[3]), .clk_stall(src[4]),
        .supply_ok(!src[5]), .reset_pin_n(!src[2]), .sys_rst_req,
        .comp_rst_en, .clk_det_en, .sup_rst_en);
    initial forever #2 clk = ~clk;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        sfr_addr = RCR_ADDR;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        check(sfr_rdata, exp);
    endtask : rd
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial begin
        #20000;
        err_total++;
        finish_test;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        rd(RCR_ADDR, 8'h02);
        rd(8'hEE, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr(en_tab[i]);
            check({5'h00, comp_rst_en, clk_det_en, sup_rst_en},
                {5'h00, en_tab[i][5], en_tab[i][2], en_tab[i][1]});
            seen = 1'b0;
            src = (i < 6) ? 6'h01 << i : 6'h00;
            repeat (4) begin
                @(negedge clk);
                seen |= sys_rst_req;
            end
            src = 6'h00;
            for (int n = 0; n < 50 && sys_rst_req !== 1'b0; n++)
                @(negedge clk);
            check({7'h00, sys_rst_req}, 8'h00);
            check({7'h00, seen}, 8'h01);
            rd(RCR_ADDR, exp_tab[i]);
            rd(RCR_ADDR, exp_tab[i]);
        end
        wr(8'h24);
        check({6'h00, comp_rst_en, clk_det_en}, 8'h03);
        wr(8'h00);
        check({6'h00, comp_rst_en, clk_det_en}, 8'h00);
        ce = 1'b0;
        wr(8'h24);
        ce = 1'b1;
        check({6'h00, comp_rst_en, clk_det_en}, 8'h00);
        src = 6'h18;
        repeat (6) @(negedge clk);
        check({7'h00, sys_rst_req}, 8'h00);
        src = 6'h00;
        rd(RCR_ADDR, 8'h10);
        finish_test;
    end
endmodule : reset_cause_register_test
